// *** core/transceiver_function_latch.sv ***
`timescale 1ns/100ps
`default_nettype none
module transceiver_function_latch
    import fn_latch_pkg::*;
(
    // core clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // three-wire serial port from the host
    input wire logic SER_DATA,
    input wire logic SER_CLK,
    input wire logic LOAD_STROBE,
    // power-down pins
    input wire logic RX_SLEEP_PIN,
    input wire logic TX_SLEEP_PIN,
    // synthesizer controls
    output logic PRESCALER_MOD64,
    output logic PD_POLARITY_POS,
    output logic PUMP_GAIN_4X,
    output logic PUMP_FLOAT,
    // chain power
    output logic RX_CHAIN_ON,
    output logic TX_CHAIN_ON,
    // general outputs
    output logic GP_OUT0,
    output logic GP_OUT1,
    output logic GP_OUT2,
    // power-down mode status
    output logic MODE_SOFTWARE,
    output logic MODE_PIN,
    output logic MODE_TEST,
    // demodulator settings
    output logic [DEMOD_W-1:0] DEMOD_FIELDS,
    // loads routed to the counter latches
    output logic FEEDBACK_LOAD,
    output logic REFERENCE_LOAD,
    output logic [LATCH_W-1:0] LOAD_DATA
);

    // ------------------------------------------------------------
    // synchronisation of all pins
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic data_s;
    logic sclk_s;
    logic load_s;
    logic rx_pin_s;
    logic tx_pin_s;

    assign pins_async = {TX_SLEEP_PIN, RX_SLEEP_PIN, LOAD_STROBE, SER_CLK, SER_DATA};

    // data and clock share the same delay, so host setup margin is kept
    pin_sync2 #(
        .W(SYNC_W)
    ) u_sync (
        .clk(CORE_CLK),
        .rst(RESET),
        .d(pins_async),
        .q(pins_sync)
    );

    assign data_s = pins_sync[0];
    assign sclk_s = pins_sync[1];
    assign load_s = pins_sync[2];
    assign rx_pin_s = pins_sync[3];
    assign tx_pin_s = pins_sync[4];

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic sclk_d_reg;
    logic load_d_reg;
    logic sclk_rise;
    logic load_rise;

    // previous synchronised levels
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            sclk_d_reg <= 1'b0;
            load_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            load_d_reg <= load_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign load_rise = load_s & ~load_d_reg;

    // ------------------------------------------------------------
    // serial shift register
    // ------------------------------------------------------------
    logic [SHIFT_W-1:0] shift_reg;
    logic [SHIFT_W-1:0] shift_next;

    assign shift_next = sclk_rise ? {shift_reg[SHIFT_W-2:0], data_s} : shift_reg;

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            shift_reg <= SHIFT_RESET;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // ------------------------------------------------------------
    // address decode of the trailing select bits
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_bits;
    logic [LATCH_W-1:0] word_fields;
    logic load_fn;
    logic load_fb;
    logic load_ref;

    assign ctrl_bits = shift_reg[CTRL_W-1:0];
    assign word_fields = shift_reg[SHIFT_W-1:CTRL_W];
    assign load_fn = load_rise & shift_reg[SEL_LOW_POS];
    assign load_fb = load_rise & (ctrl_bits == CTRL_FEEDBACK);
    assign load_ref = load_rise & (ctrl_bits == CTRL_REFERENCE);

    // ------------------------------------------------------------
    // function latch
    // ------------------------------------------------------------
    logic [LATCH_W-1:0] fn_reg;
    logic [LATCH_W-1:0] fn_next;

    // whole word copied at once; reserved field stored as sent
    assign fn_next = load_fn ? word_fields : fn_reg;

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            fn_reg <= LATCH_RESET;
        end else begin
            fn_reg <= fn_next;
        end
    end

    // ------------------------------------------------------------
    // counter load strobes
    // ------------------------------------------------------------
    logic fb_load_reg;
    logic ref_load_reg;
    logic [LATCH_W-1:0] load_data_reg;
    logic [LATCH_W-1:0] load_data_next;

    // data bus only moves on a counter load, so it stays quiet otherwise
    assign load_data_next = (load_fb | load_ref) ? word_fields : load_data_reg;

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            fb_load_reg <= 1'b0;
            ref_load_reg <= 1'b0;
            load_data_reg <= LATCH_RESET;
        end else begin
            fb_load_reg <= load_fb;
            ref_load_reg <= load_ref;
            load_data_reg <= load_data_next;
        end
    end

    // ------------------------------------------------------------
    // power-down mode and chain control
    // ------------------------------------------------------------
    sleep_mode_e mode;
    logic soft_mode;
    logic pin_mode;
    logic rx_on_next;
    logic tx_on_next;
    logic gp1_next;
    logic gp2_next;

    assign mode = decode_mode(fn_reg[FLD_MODE_A], fn_reg[FLD_MODE_B]);
    assign soft_mode = (mode == MODE_SOFT);
    assign pin_mode = (mode == fn_latch_pkg::MODE_PIN); // scoped: the status port shares this name

    // rx by field, rx by pin; test combos leave chains on
    assign rx_on_next = soft_mode ? ~fn_reg[FLD_RX_SLEEP] :
                        pin_mode ? rx_pin_s : 1'b1;
    assign tx_on_next = soft_mode ? ~fn_reg[FLD_TX_SLEEP] :
                        pin_mode ? tx_pin_s : 1'b1;
    // outputs 1 and 2 held low outside software mode
    assign gp1_next = soft_mode & fn_reg[FLD_GP_OUT1];
    assign gp2_next = soft_mode & fn_reg[FLD_GP_OUT2];

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic presc_reg;
    logic pol_reg;
    logic gain_reg;
    logic float_reg;
    logic rx_on_reg;
    logic tx_on_reg;
    logic gp0_reg;
    logic gp1_reg;
    logic gp2_reg;
    logic msoft_reg;
    logic mpin_reg;
    logic mtest_reg;
    logic [DEMOD_W-1:0] demod_reg;

    // synthesizer settings, all from one latch value
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            presc_reg <= 1'b0;
            pol_reg <= 1'b0;
            gain_reg <= 1'b0;
            float_reg <= 1'b0;
        end else begin
            presc_reg <= fn_reg[FLD_PRESCALER];
            pol_reg <= fn_reg[FLD_POLARITY];
            gain_reg <= fn_reg[FLD_PUMP_GAIN];
            float_reg <= fn_reg[FLD_PUMP_FLOAT];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            rx_on_reg <= 1'b1;
            tx_on_reg <= 1'b1;
            gp0_reg <= 1'b0;
            gp1_reg <= 1'b0;
            gp2_reg <= 1'b0;
        end else begin
            rx_on_reg <= rx_on_next;
            tx_on_reg <= tx_on_next;
            gp0_reg <= fn_reg[FLD_GP_OUT0];
            gp1_reg <= gp1_next;
            gp2_reg <= gp2_next;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            msoft_reg <= 1'b1;
            mpin_reg <= 1'b0;
            mtest_reg <= 1'b0;
            demod_reg <= '0;
        end else begin
            msoft_reg <= soft_mode;
            mpin_reg <= pin_mode;
            mtest_reg <= (mode == fn_latch_pkg::MODE_TEST); // scoped: port of the same name
            demod_reg <= fn_reg[LATCH_W-1:FLD_DEMOD_LO];
        end
    end

    // ------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------
    assign PRESCALER_MOD64 = presc_reg;
    assign PD_POLARITY_POS = pol_reg;
    assign PUMP_GAIN_4X = gain_reg;
    assign PUMP_FLOAT = float_reg;
    assign RX_CHAIN_ON = rx_on_reg;
    assign TX_CHAIN_ON = tx_on_reg;
    assign GP_OUT0 = gp0_reg;
    assign GP_OUT1 = gp1_reg;
    assign GP_OUT2 = gp2_reg;
    assign MODE_SOFTWARE = msoft_reg;
    assign MODE_PIN = mpin_reg;
    assign MODE_TEST = mtest_reg;
    assign DEMOD_FIELDS = demod_reg;
    assign FEEDBACK_LOAD = fb_load_reg;
    assign REFERENCE_LOAD = ref_load_reg;
    assign LOAD_DATA = load_data_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    sequence s_fn_load;
        load_rise ##0 shift_reg[SEL_LOW_POS];
    endsequence
    sequence s_fb_pulse;
        FEEDBACK_LOAD ##1 !FEEDBACK_LOAD;
    endsequence
    a_shift_msb_first: assert property (
        sclk_rise |=> shift_reg == {$past(shift_reg[SHIFT_W-2:0]), $past(data_s)})
        else $error("shift register did not take data on serial clock edge");

    a_latch_load_word: assert property (
        s_fn_load |=> fn_reg == $past(word_fields))
        else $error("function latch not loaded from upper shift bits");

    a_latch_holds: assert property (
        !load_fn |=> $stable(fn_reg))
        else $error("function latch changed without a load");

    a_route_feedback: assert property (
        load_rise && ctrl_bits == CTRL_FEEDBACK |=> s_fb_pulse)
        else $error("feedback load pulse missing or too long");

    a_route_reference: assert property (
        REFERENCE_LOAD |-> !FEEDBACK_LOAD && $past(ctrl_bits) == CTRL_REFERENCE)
        else $error("reference load with wrong select bits");

    // prescaler follows the loaded field two cycles after load
    a_prescaler_sel: assert property (
        s_fn_load |=> ##1 PRESCALER_MOD64 == $past(fn_reg[FLD_PRESCALER]))
        else $error("prescaler modulus does not follow its field");

    a_pump_fields: assert property (
        ##1 PUMP_GAIN_4X == $past(fn_reg[FLD_PUMP_GAIN])
            && PUMP_FLOAT == $past(fn_reg[FLD_PUMP_FLOAT]))
        else $error("charge pump controls do not follow latch");

    a_rx_soft_sleep: assert property (
        soft_mode && fn_reg[FLD_RX_SLEEP] |=> !RX_CHAIN_ON)
        else $error("receive chain on while software sleep set");

    a_tx_pin_sleep: assert property (
        pin_mode |=> TX_CHAIN_ON == $past(tx_pin_s))
        else $error("transmit chain does not follow its pin");

    // outputs 1 and 2 gated by mode
    a_gp_gated: assert property (
        !soft_mode |=> !GP_OUT1 && !GP_OUT2 && GP_OUT0 == $past(fn_reg[FLD_GP_OUT0]))
        else $error("general outputs wrong outside software mode");
endmodule : transceiver_function_latch
`default_nettype wire

// *** core/fn_latch_pkg.sv ***
package fn_latch_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int SHIFT_W = 20;
    localparam int LATCH_W = 18;
    localparam int CTRL_W = 2;
    localparam int DEMOD_W = 6;
    localparam int SYNC_W = 5;

    // ------------------------------------------------------------
    // select bits in the shift word
    // ------------------------------------------------------------
    localparam int SEL_LOW_POS = 0;
    localparam logic [CTRL_W-1:0] CTRL_FEEDBACK = 2'h0;
    localparam logic [CTRL_W-1:0] CTRL_REFERENCE = 2'h2;

    // ------------------------------------------------------------
    // field positions inside the function latch
    // ------------------------------------------------------------
    localparam int FLD_PRESCALER = 0;
    localparam int FLD_POLARITY = 1;
    localparam int FLD_PUMP_GAIN = 2;
    localparam int FLD_PUMP_FLOAT = 3;
    localparam int FLD_RESERVED = 4;
    localparam int FLD_RX_SLEEP = 5;
    localparam int FLD_TX_SLEEP = 6;
    localparam int FLD_GP_OUT0 = 7;
    localparam int FLD_GP_OUT1 = 8;
    localparam int FLD_GP_OUT2 = 9;
    localparam int FLD_MODE_A = 10;
    localparam int FLD_MODE_B = 11;
    localparam int FLD_DEMOD_LO = 12;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [LATCH_W-1:0] LATCH_RESET = 18'h00000;
    localparam logic [SHIFT_W-1:0] SHIFT_RESET = 20'h00000;

    // power-down control source
    typedef enum logic [1:0] {MODE_SOFT, MODE_PIN, MODE_TEST} sleep_mode_e;

    // decode the two mode fields
    function automatic sleep_mode_e decode_mode(input logic a, input logic b);
        if (a != b) begin
            return MODE_TEST;
        end
        return a ? MODE_PIN : MODE_SOFT;
    endfunction : decode_mode

endpackage : fn_latch_pkg

// *** core/pin_sync2.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_sync2
    import fn_latch_pkg::*;
#(
    parameter int W = SYNC_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] hold_reg;

    // ------------------------------------------------------------
    // two flops; first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            hold_reg <= '0;
        end else begin
            meta_reg <= d;
            hold_reg <= meta_reg;
        end
    end

    assign q = hold_reg;

endmodule : pin_sync2
`default_nettype wire

// *** testbench/host_serial_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
    // core clock used only to pace the link
    input wire logic CORE_CLK,
    // three-wire port toward the device
    output logic SER_DATA,
    output logic SER_CLK,
    output logic LOAD_STROBE
);
    // ------------------------------------------------------------
    // idle levels: link clock stands still between frames
    // ------------------------------------------------------------
    initial begin
        SER_DATA = 1'b0;
        SER_CLK = 1'b0;
        LOAD_STROBE = 1'b0;
    end

    // four core cycles per half period make a 200 ns link clock
    task automatic half_bit();
        repeat (4) @(negedge CORE_CLK);
    endtask : half_bit

    // ------------------------------------------------------------
    // one whole 20-bit frame, then the strobe
    // ------------------------------------------------------------
    // msb first, select bits last
    // mode fields differ only where a test commands it
    task automatic send(input logic [19:0] word);
        for (int i = 19; i >= 0; i--) begin
            SER_DATA = word[i];
            half_bit();
            SER_CLK = 1'b1;
            half_bit();
            SER_CLK = 1'b0;
        end
        // released data shows the inverse so no one leans on a stale bit
        SER_DATA = ~word[0];
        half_bit();
        LOAD_STROBE = 1'b1;
        half_bit();
        LOAD_STROBE = 1'b0;
        half_bit();
    endtask : send
endmodule : host_serial_model
`default_nettype wire

// *** testbench/transceiver_function_latch_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module transceiver_function_latch_test
    import fn_latch_pkg::*;
;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int CYCLE_LIMIT = 20000;
    typedef struct packed {
        logic [17:0] fld;
        logic hi;
        logic rxp;
        logic txp;
        logic [17:0] exp;
    } row_s;
    logic core_clk;
    logic reset;
    logic rx_pin;
    logic tx_pin;
    logic ser_data, ser_clk, load_strobe;
    logic pre, pol, gain, flt, rx_on, tx_on, gp0, gp1, gp2, m_soft, m_pin, m_test;
    logic fb_load, ref_load;
    logic [DEMOD_W-1:0] demod;
    logic [LATCH_W-1:0] load_data;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int fb_n = 0;
    int ref_n = 0;
    row_s rows [7];
    // all field outputs packed in one word for the tables
    wire [17:0] obs = {demod, m_test, m_pin, m_soft, gp2, gp1, gp0,
                       tx_on, rx_on, flt, gain, pol, pre};

    // ------------------------------------------------------------
    // device and host
    // ------------------------------------------------------------
    transceiver_function_latch i_dut (
        .CORE_CLK(core_clk), .RESET(reset), .SER_DATA(ser_data),
        .SER_CLK(ser_clk), .LOAD_STROBE(load_strobe),
        .RX_SLEEP_PIN(rx_pin), .TX_SLEEP_PIN(tx_pin),
        .PRESCALER_MOD64(pre), .PD_POLARITY_POS(pol), .PUMP_GAIN_4X(gain),
        .PUMP_FLOAT(flt), .RX_CHAIN_ON(rx_on), .TX_CHAIN_ON(tx_on),
        .GP_OUT0(gp0), .GP_OUT1(gp1), .GP_OUT2(gp2),
        .MODE_SOFTWARE(m_soft), .MODE_PIN(m_pin), .MODE_TEST(m_test),
        .DEMOD_FIELDS(demod), .FEEDBACK_LOAD(fb_load),
        .REFERENCE_LOAD(ref_load), .LOAD_DATA(load_data)
    );
    host_serial_model i_host (
        .CORE_CLK(core_clk), .SER_DATA(ser_data),
        .SER_CLK(ser_clk), .LOAD_STROBE(load_strobe)
    );

    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // counts high cycles of the load pulses; also the hang limit
    always @(posedge core_clk) begin
        cycles++;
        if (fb_load === 1'b1) fb_n++;
        if (ref_load === 1'b1) ref_n++;
        if (cycles == CYCLE_LIMIT) begin
            miscompares++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // compare and close
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [17:0] e, input logic [17:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_n

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        rx_pin = 1'b1;
        tx_pin = 1'b1;
        // fields, select high, rx pin, tx pin, expected outputs
        rows = '{'{18'h00001, 1'b0, 1'b1, 1'b1, 18'h00231},
                 '{18'h2A32E, 1'b1, 1'b1, 1'b1, 18'h2A3AE},
                 '{18'h150C0, 1'b0, 1'b1, 1'b1, 18'h15250},
                 '{18'h00F60, 1'b0, 1'b1, 1'b0, 18'h00410},
                 '{18'h00FE0, 1'b1, 1'b0, 1'b1, 18'h00460},
                 '{18'h00760, 1'b0, 1'b0, 1'b0, 18'h00830},
                 '{18'h00B60, 1'b0, 1'b0, 1'b0, 18'h00830}};
        wait_n(12);
        reset = 1'b0;
        wait_n(1);
        chk("reset outputs", 18'h00230, obs);
        chk("reset load data", 18'h00000, load_data);
        // table of function loads, select high bit varies
        foreach (rows[i]) begin
            rx_pin = rows[i].rxp;
            tx_pin = rows[i].txp;
            i_host.send({rows[i].fld, rows[i].hi, 1'b1});
            wait_n(2);
            chk("row outputs", rows[i].exp, obs);
        end
        chk("no counter load", 18'h00000, 18'(fb_n + ref_n));
        // counter routes leave the function latch alone
        i_host.send({18'h2AF35, 2'h0});
        wait_n(2);
        chk("feedback pulses", 18'h00001, 18'(fb_n));
        chk("feedback data", 18'h2AF35, load_data);
        chk("held outputs", 18'h00830, obs);
        i_host.send({18'h0153A, 2'h2});
        wait_n(2);
        chk("reference pulses", 18'h00001, 18'(ref_n));
        chk("feedback stays", 18'h00001, 18'(fb_n));
        chk("reference data", 18'h0153A, load_data);
        chk("held outputs", 18'h00830, obs);
        // pins steer the chains in pin mode without a new load
        i_host.send({18'h00F60, 2'h1});
        rx_pin = 1'b0;
        tx_pin = 1'b1;
        wait_n(4);
        chk("pin follow a", 18'h00420, obs);
        rx_pin = 1'b1;
        tx_pin = 1'b0;
        wait_n(4);
        chk("pin follow b", 18'h00410, obs);
        // second reset in mid-run
        reset = 1'b1;
        wait_n(2);
        reset = 1'b0;
        wait_n(1);
        chk("rerun reset", 18'h00230, obs);
        test_done();
    end
endmodule : transceiver_function_latch_test
`default_nettype wire
